// ==== bench/brog_far_side.sv ====
`timescale 1ns/1ns
`default_nettype none
module brog_far_side (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        wantBrake,
  input  wire logic [15:0] wantVolts,
  output logic             brakeRequest,
  output logic      [15:0] busVolts
);
  // Demand ignores the trip on purpose, so the guard alone must hold the switch off.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      brakeRequest <= 1'b0;
      busVolts     <= 16'h0000;
    end else begin
      brakeRequest <= wantBrake;
      busVolts     <= wantVolts;
    end
  end
endmodule : brog_far_side
`default_nettype wire

// ==== bench/brog_guard_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module brog_guard_props (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic brakeRequest,
  input wire logic brakeGate,
  input wire logic brakeAlarm,
  input wire logic brakeTrip
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_gate_request: assert property (brakeGate |-> $past(brakeRequest))
    else $error("gate on without demand");
  a_alarm_gate: assert property (brakeAlarm |-> $past(brakeGate))
    else $error("alarm while switch idle");
  a_trip_blocks: assert property (brakeTrip |=> !brakeGate)
    else $error("gate on while tripped");
  a_trip_clear: assert property ($fell(brakeTrip) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i))
    else $error("trip dropped without a clearing write");
endmodule : brog_guard_props
`default_nettype wire

// ==== bench/brog_guard_test.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "brog_defines.svh"
module brog_guard_test;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, wantBrake = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic        ack, req, gate, alarm, trip;
  logic [15:0] volts, wantVolts = 16'h0000;
  int          badCount = 0;
  int          numChecks = 0;

  always #10 clk_sys = ~clk_sys;

  brog_guard #(.TICK_CYCLES(200)) brog_guard_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rd), .wb_ack_o(ack), .brakeRequest(req), .busVolts(volts),
    .brakeGate(gate), .brakeAlarm(alarm), .brakeTrip(trip));
  brog_far_side brog_far_side_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .wantBrake(wantBrake), .wantVolts(wantVolts), .brakeRequest(req), .busVolts(volts));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    wdat <= d;
    do begin
      @(posedge clk_sys);
    end while (ack !== 1'b1);
    rdat = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys);
  endtask : acc

  // The level moves only once per model tick, so polling for a change beats guessing the tick phase.
  task automatic waitLvl(input logic [31:0] old);
    int n;
    n = 0;
    do begin
      acc(`BROG_ADR_LEVEL, 1'b0, 32'h0);
      n++;
    end while (rdat === old && n < 400);
    // A level that never moves within the poll limit is a fault of its own.
    if (rdat === old) begin
      badCount++;
    end
  endtask : waitLvl

  task automatic wrapUp();
    if (badCount == 0 && numChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrapUp

  // The sequence needs some fifty model ticks at most; this span leaves a wide margin.
  initial begin
    #1000000;
    badCount++;
    wrapUp();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 7; i++) begin
      acc(8'(i * 4), 1'b0, 32'h0);
      chk("reset read", rdat, 32'h0);
    end
    acc(`BROG_ADR_POWER, 1'b1, 32'd100);
    acc(`BROG_ADR_RES, 1'b1, 32'd14);
    wantVolts <= 16'd35;
    wantBrake <= 1'b1;
    repeat (700) @(posedge clk_sys);
    chk("gate", gate, 1'b1);
    acc(`BROG_ADR_LEVEL, 1'b0, 32'h0);
    chk("level unconfigured", rdat, 32'h0);
    acc(`BROG_ADR_STATUS, 1'b0, 32'h0);
    chk("status unconfigured", rdat, 32'h0);
    acc(`BROG_ADR_TAU, 1'b1, 32'd1);
    waitLvl(32'h0);
    chk("level steady", rdat, 32'h0e000);
    chk("alarm", alarm, 1'b1);
    acc(`BROG_ADR_STATUS, 1'b0, 32'h0);
    chk("status alarm", rdat, 32'h9);
    acc(`BROG_ADR_TAU, 1'b1, 32'd2);
    wantBrake <= 1'b0;
    waitLvl(32'h0e000);
    chk("level decay", rdat, 32'h07000);
    waitLvl(32'h07000);
    chk("level decay", rdat, 32'h03800);
    chk("alarm idle", alarm, 1'b0);
    acc(`BROG_ADR_RES, 1'b1, 32'd10);
    wantVolts <= 16'd100;
    for (int m = 0; m < 4; m++) begin
      acc(`BROG_ADR_MODE, 1'b1, 32'(m));
      acc(`BROG_ADR_TAU, 1'b1, (m < 2) ? 32'd1 : 32'd32);
      wantBrake <= 1'b1;
      repeat (20) if (rdat !== `BROG_LVL_FULL) waitLvl(rdat);
      chk("level full", rdat, `BROG_LVL_FULL);
      repeat (3) @(posedge clk_sys);
      chk("trip", trip, m < 2);
      chk("gate held off", gate, 1'b0);
      acc(`BROG_ADR_STATUS, 1'b0, 32'h0);
      chk("status", rdat, (m < 2) ? 32'ha : 32'hc);
      if (m >= 2) begin
        waitLvl(`BROG_LVL_FULL);
        chk("level hold", rdat, 32'h0f800);
        chk("gate held off", gate, 1'b0);
        waitLvl(32'h0f800);
        repeat (3) @(posedge clk_sys);
        chk("gate resumed", gate, 1'b1);
      end
      acc(`BROG_ADR_TAU, 1'b1, 32'd1);
      wantBrake <= 1'b0;
      acc(`BROG_ADR_LEVEL, 1'b0, 32'h0);
      repeat (20) if (rdat !== 32'h0) waitLvl(rdat);
      chk("trip sticky", trip, m < 2);
      acc(`BROG_ADR_STATUS, 1'b1, 32'h2);
      chk("trip cleared", trip, 1'b0);
    end
    wrapUp();
  end
endmodule : brog_guard_test

bind brog_guard brog_guard_props brog_guard_props_inst (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .brakeRequest(brakeRequest),
  .brakeGate(brakeGate), .brakeAlarm(brakeAlarm), .brakeTrip(brakeTrip));
`default_nettype wire

// ==== rtl/brog_defines.svh ====
`ifndef BROG_DEFINES_SVH
`define BROG_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define BROG_ADR_POWER   8'h00
`define BROG_ADR_TAU     8'h04
`define BROG_ADR_RES     8'h08
`define BROG_ADR_MODE    8'h0c
`define BROG_ADR_LEVEL   8'h10
`define BROG_ADR_STATUS  8'h14

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define BROG_ST_ALARM    0
`define BROG_ST_TRIP     1
`define BROG_ST_SUSP     2
`define BROG_ST_CFG      3
`define BROG_MODE_RST    2'h0
`define BROG_CFG_RST     16'h0000

// ----------------------------------------------------------------------------
// Thermal scale, 17'h10000 is full scale
// ----------------------------------------------------------------------------
`define BROG_LVL_FULL    17'h10000
`define BROG_LVL_ALARM   17'h0c000
`define BROG_LVL_RESUME  17'h0f333
`define BROG_FRAC_W      8
`define BROG_TGT_MAX     18'h3ffff
`define BROG_DIV_LAST    6'h2f

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define BROG_CLK_NS      20
`define BROG_TICK_NS     1000000
`define BROG_TICK_CYCLES (`BROG_TICK_NS / `BROG_CLK_NS)

`endif

// ==== rtl/brog_guard.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "brog_defines.svh"

module brog_guard #(
  parameter int TICK_CYCLES = `BROG_TICK_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        brakeRequest,
  input  wire logic [15:0] busVolts,
  output logic             brakeGate,
  output logic             brakeAlarm,
  output logic             brakeTrip
);

  brog_pkg::brog_guard_t r_reg;
  brog_pkg::brog_guard_t r_next;

  logic [16:0] level;
  logic        cfgValid;
  logic        hit;
  logic        wr;
  logic        atFull;
  logic        belowResume;
  logic        tripClr;
  logic        tripSet;
  logic [31:0] rdData;

  // --------------------------------------------------------------------------
  // Byte-lane merge for the 16-bit configuration registers
  // --------------------------------------------------------------------------
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] d,
    input logic [3:0]  sel
  );
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // --------------------------------------------------------------------------
  // Trip clear decode
  // --------------------------------------------------------------------------
  // Only a status write with bit 1 set in an enabled low byte clears the trip;
  // every other write to status is ignored, as the level and status are read-only.
  function automatic logic isTripClear(
    input logic [7:0]  adr,
    input logic [31:0] d,
    input logic [3:0]  sel
  );
    isTripClear = (adr == `BROG_ADR_STATUS) && sel[0] && d[`BROG_ST_TRIP];
  endfunction : isTripClear

  // --------------------------------------------------------------------------
  // Thermal model
  // --------------------------------------------------------------------------
  // all three values nonzero
  assign cfgValid = (r_reg.power != 16'h0) && (r_reg.tau != 16'h0) && (r_reg.res != 16'h0);

  // One divider is shared by both steps of the model, so a tick costs about a
  // hundred clocks; TICK_CYCLES must leave that much room between ticks.
  brog_thermal_model brog_thermal_model_inst (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .tick        (r_reg.tick),
    .cfgValid    (cfgValid),
    .conducting  (r_reg.gate),
    .busVolts    (busVolts),
    .ratedPower  (r_reg.power),
    .timeConstMs (r_reg.tau),
    .resistance  (r_reg.res),
    .level       (level)
  );

  assign wb_dat_o   = r_reg.dat;
  assign wb_ack_o   = r_reg.ack;
  assign brakeGate  = r_reg.gate;
  assign brakeAlarm = r_reg.alarm;
  assign brakeTrip  = r_reg.tripped;

  // --------------------------------------------------------------------------
  // Read multiplexer
  // --------------------------------------------------------------------------
  always_comb begin
    rdData = 32'h0;
    unique case (wb_adr_i)
      `BROG_ADR_POWER: begin
        rdData = {16'h0, r_reg.power};
      end
      `BROG_ADR_TAU: begin
        rdData = {16'h0, r_reg.tau};
      end
      `BROG_ADR_RES: begin
        rdData = {16'h0, r_reg.res};
      end
      `BROG_ADR_MODE: begin
        rdData = {30'h0, r_reg.mode};
      end
      `BROG_ADR_LEVEL: begin
        rdData = {15'h0, level};
      end
      `BROG_ADR_STATUS: begin
        rdData[`BROG_ST_ALARM] = r_reg.alarm;
        rdData[`BROG_ST_TRIP]  = r_reg.tripped;
        rdData[`BROG_ST_SUSP]  = r_reg.suspended;
        // The configured bit tells software why the level stays at zero.
        rdData[`BROG_ST_CFG]   = cfgValid;
      end
      default: begin
        rdData = 32'h0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    r_next = r_reg;

    // ------------------------------------------------------------------------
    // Model tick
    // ------------------------------------------------------------------------
    // The model is stepped once per tick; configuration written between
    // ticks is picked up at the next one, so a change of time constant or
    // resistance shows in the level only after up to two ticks.
    if (r_reg.tickCnt == 32'(TICK_CYCLES - 1)) begin
      r_next.tickCnt = 32'h0;
      r_next.tick    = 1'b1;
    end else begin
      r_next.tickCnt = r_reg.tickCnt + 32'h1;
      r_next.tick    = 1'b0;
    end

    // ------------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------------
    // Classic single-cycle Wishbone slave: one wait state, then ack. A strobe
    // that is still held while ack stands is not taken again, which keeps a
    // slow master from writing twice or clearing the trip twice.
    hit        = wb_cyc_i && wb_stb_i && !r_reg.ack;
    wr         = hit && wb_we_i;
    r_next.ack = hit;
    r_next.dat = hit ? rdData : 32'h0;

    if (wr) begin
      unique case (wb_adr_i)
        `BROG_ADR_POWER: begin
          r_next.power = merge16(r_reg.power, wb_dat_i, wb_sel_i);
        end
        `BROG_ADR_TAU: begin
          r_next.tau = merge16(r_reg.tau, wb_dat_i, wb_sel_i);
        end
        `BROG_ADR_RES: begin
          r_next.res = merge16(r_reg.res, wb_dat_i, wb_sel_i);
        end
        `BROG_ADR_MODE: begin
          if (wb_sel_i[0]) begin
            r_next.mode = wb_dat_i[1:0];
          end
        end
        default: begin
          // Level and status ignore writes here; the trip clear is decoded
          // below so that it can be weighed against a new trip.
        end
      endcase
    end

    // ------------------------------------------------------------------------
    // Overload actions
    // ------------------------------------------------------------------------
    // Without all three resistor values the level is held at zero, and
    // neither a trip nor a suspension can start.
    atFull      = cfgValid && (level >= `BROG_LVL_FULL);
    belowResume = (level < `BROG_LVL_RESUME);

    // trip in modes 0 and 1
    tripSet = atFull && !r_reg.mode[1];
    tripClr = wr && isTripClear(wb_adr_i, wb_dat_i, wb_sel_i);
    // A new trip condition outlasts a clear arriving in the same cycle.
    r_next.tripped = tripSet || (r_reg.tripped && !tripClr);

    // Moving back to a trip mode lifts the suspension at once; a level still
    // at full scale then trips on the same edge instead.
    // suspend instead of trip
    r_next.suspended = r_reg.mode[1] && (atFull || (r_reg.suspended && !belowResume));

    // The gate follows the request one cycle late; a suspension or trip
    // takes the switch off before the next pulse.
    r_next.gate = brakeRequest && !r_reg.suspended && !r_reg.tripped;

    r_next.alarm = (level > `BROG_LVL_ALARM) && r_reg.gate;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  // Configuration clears to zero, so the level stays at zero and nothing trips until software has
  // loaded all three resistor values; the gate still follows the request meanwhile.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg       <= '0;
      r_reg.power <= `BROG_CFG_RST;
      r_reg.tau   <= `BROG_CFG_RST;
      r_reg.res   <= `BROG_CFG_RST;
      r_reg.mode  <= `BROG_MODE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule : brog_guard
`default_nettype wire

// ==== rtl/brog_pkg.sv ====
package brog_pkg;

  typedef enum logic [1:0] {TM_IDLE, TM_TARGET, TM_STEP} brog_tm_state_t;

  typedef struct packed {
    brog_tm_state_t st;
    logic [5:0]     cnt;
    logic [32:0]    rem;
    logic [47:0]    quo;
    logic [31:0]    den;
    logic [25:0]    target;
    logic           up;
    logic [24:0]    level;
  } brog_tm_t;

  typedef struct packed {
    logic [31:0] tickCnt;
    logic        tick;
    logic [15:0] power;
    logic [15:0] tau;
    logic [15:0] res;
    logic [1:0]  mode;
    logic        tripped;
    logic        suspended;
    logic        alarm;
    logic        gate;
    logic        ack;
    logic [31:0] dat;
  } brog_guard_t;

endpackage : brog_pkg

// ==== rtl/brog_thermal_model.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "brog_defines.svh"

module brog_thermal_model (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        tick,
  input  wire logic        cfgValid,
  input  wire logic        conducting,
  input  wire logic [15:0] busVolts,
  input  wire logic [15:0] ratedPower,
  input  wire logic [15:0] timeConstMs,
  input  wire logic [15:0] resistance,
  output logic      [16:0] level
);

  brog_pkg::brog_tm_t r_reg;
  brog_pkg::brog_tm_t r_next;

  logic [32:0] trial;
  logic        qbit;
  logic [47:0] qNext;
  logic [17:0] tgt;
  logic [25:0] t26;
  logic [25:0] l26;
  logic [25:0] step;
  logic [26:0] sum27;
  logic [25:0] nl;
  logic [25:0] full26;
  logic [31:0] vsq;

  assign level = r_reg.level[24:`BROG_FRAC_W];

  // --------------------------------------------------------------------------
  // One tick: a shared divider first finds the steady level for the present
  // power, then moves the level a tau-th of the way there.
  // --------------------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    vsq    = busVolts * busVolts;
    trial  = {r_reg.rem[31:0], r_reg.quo[47]};
    qbit   = (trial >= {1'b0, r_reg.den});
    qNext  = {r_reg.quo[46:0], qbit};
    tgt    = (qNext > 48'(`BROG_TGT_MAX)) ? `BROG_TGT_MAX : qNext[17:0];
    t26    = {tgt, {`BROG_FRAC_W{1'b0}}};
    l26    = {1'b0, r_reg.level};
    full26 = {1'b0, `BROG_LVL_FULL, {`BROG_FRAC_W{1'b0}}};
    // Truncation would stall the level short of its target, so always move.
    step   = (qNext[25:0] == 26'h0) ? 26'h1 : qNext[25:0];
    sum27  = {1'b0, l26} + {1'b0, step};
    if (r_reg.up) begin
      nl = (sum27 > {1'b0, r_reg.target}) ? r_reg.target : sum27[25:0];
    end else begin
      nl = (step >= l26 - r_reg.target) ? r_reg.target : l26 - step;
    end
    if (nl > full26) begin
      nl = full26;
    end
    unique case (r_reg.st)
      brog_pkg::TM_IDLE: begin
        if (tick) begin
          if (!cfgValid) begin
            r_next.level = '0;
          end else begin
            r_next.rem = '0;
            r_next.quo = conducting ? {vsq, 16'h0000} : 48'h0;
            r_next.den = resistance * ratedPower;
            r_next.cnt = `BROG_DIV_LAST;
            r_next.st  = brog_pkg::TM_TARGET;
          end
        end
      end
      brog_pkg::TM_TARGET, brog_pkg::TM_STEP: begin
        r_next.rem = qbit ? trial - {1'b0, r_reg.den} : trial;
        r_next.quo = qNext;
        r_next.cnt = r_reg.cnt - 6'h1;
        if (r_reg.cnt == 6'h0) begin
          if (r_reg.st == brog_pkg::TM_TARGET) begin
            r_next.target = t26;
            r_next.up     = (t26 >= l26);
            r_next.quo    = {22'h0, (t26 >= l26) ? t26 - l26 : l26 - t26};
            r_next.rem    = '0;
            r_next.den    = {16'h0, timeConstMs};
            r_next.cnt    = `BROG_DIV_LAST;
            r_next.st     = brog_pkg::TM_STEP;
          end else begin
            r_next.level = nl[24:0];
            r_next.st    = brog_pkg::TM_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg <= '{st: brog_pkg::TM_IDLE, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

endmodule : brog_thermal_model
`default_nettype wire
